// File: adc_params.svh
`ifndef ADC_PARAMS_SVH
`define ADC_PARAMS_SVH

// ****************************************************************
// Register offsets.
// ****************************************************************
`define OFS_CTRL0    8'h00
`define OFS_CTRL1    8'h01
`define OFS_CTRL2    8'h02
`define OFS_STATUS   8'h03
`define OFS_RES_BASE 4'h1

// ****************************************************************
// Field positions.
// ****************************************************************
`define CTRL0_START  6
`define CTRL0_EXT    7
`define CTRL1_RES10  2
`define CTRL1_VREF   5
`define CTRL2_SH     0
`define CTRL2_PCLK   1

// ****************************************************************
// Reset values.
// ****************************************************************
`define RST_CTRL     8'h00
`define RST_ALT_PIN  3'h1

// ****************************************************************
// Conversion lengths in conversion clock cycles.
// ****************************************************************
`define CYC_8B_PLAIN  6'h31
`define CYC_10B_PLAIN 6'h3B
`define CYC_8B_SH     6'h1C
`define CYC_10B_SH    6'h21

`endif

// File: adc_pkg.sv
package adc_pkg;

  // Operating modes of the sequencer.
  typedef enum logic [2:0] {
    MODE_ONESHOT = 3'h0,
    MODE_REPEAT  = 3'h1,
    MODE_SWEEP1X = 3'h2,
    MODE_RSWEEP0 = 3'h3,
    MODE_RSWEEP1 = 3'h4
  } mode_t;

  // Converter states, one-hot.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_CONV = 2'h2
  } state_t;

endpackage : adc_pkg

// File: sar_adc_conversion_control.sv
// Operation
// - Ladder is disconnected from the reference pin while the connect bit is clear.
// - Ten-bit result: low eight bits even byte, upper two bits odd byte.
// - Eight-bit result goes only into the even byte.
// - Each result lands in the register of the pin converted.
// - Intermediate clock is main clock halved or not; then divided by 1, 2, 4.
// - Five modes: one-shot, repeat, single sweep, repeat sweep 0 and 1.
// - Software trigger starts a conversion when the start flag turns to one.
// - External trigger falling edge starts or restarts conversion while flag set.
// - Without sample-hold a pin takes 49 or 59 conversion clocks.
// - With sample-hold a pin takes 28 or 33 conversion clocks.
// - One-shot converts the selected pin exactly once.
// - One-shot end stops and clears the flag unless external trigger used.
// - Writing zero to the start flag aborts the conversion.
// - One-shot completion raises the interrupt request.
// - One-shot input is one of pins 0 to 7, read from its register.
`timescale 1ns/1ps
`include "adc_params.svh"

module sar_adc_conversion_control (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic [7:0]      reg_rdata_out,
  input  wire logic       external_trigger_input_in,
  input  wire logic [9:0] conv_result_in,
  output logic            vref_connect_out,
  output logic [2:0]      analog_pin_sel_out,
  output logic            sample_hold_out,
  output logic            conv_active_out,
  output logic            adc_clock_tick_out,
  output logic            adc_irq_out,
  output adc_pkg::state_t conv_state_out
);
  import adc_pkg::*;

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  logic [2:0] pin_sel_q;
  mode_t      mode_q;
  logic       start_q;
  logic       ext_q;
  logic [1:0] sweep_sel_q;
  logic       res10_q;
  logic [1:0] div_sel_q;
  logic       vref_q;
  logic       sh_q;
  logic       psel_q;
  state_t     state_q;
  logic [2:0] pin_q;
  logic [2:0] alt_q;
  logic [2:0] div_q;
  logic [5:0] cnt_q;
  logic       irq_q;
  logic [7:0] rdata_q;
  logic       trg_s1_q;
  logic       trg_s2_q;
  logic       trg_s3_q;
  logic [7:0] res_lo_q [8];
  logic [1:0] res_hi_q [8];
  logic       wr_c0;
  logic       wr_c1;
  logic       wr_c2;
  logic       abort;
  logic       sw_start;
  logic       ext_start;
  logic       begin_conv;
  logic       tick;
  logic       done;
  logic [3:0] period;
  logic [2:0] period_m1;
  logic [5:0] len;
  mode_t      mode_now;
  logic [2:0] first_pin;
  logic       stop_at_end;
  logic       irq_at_end;
  logic [2:0] next_pin;
  logic [2:0] last_pin;
  logic [7:0] rd_mux;

  // ****************************************************************
  // Register write decode.
  // ****************************************************************
  assign wr_c0 = reg_wr_in && (reg_addr_in == `OFS_CTRL0);
  assign wr_c1 = reg_wr_in && (reg_addr_in == `OFS_CTRL1);
  assign wr_c2 = reg_wr_in && (reg_addr_in == `OFS_CTRL2);

  // Control register 0 fields other than the start flag.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_sel_q <= 3'h0;
      mode_q    <= MODE_ONESHOT;
      ext_q     <= 1'b0;
    end else if (wr_c0) begin
      pin_sel_q <= reg_wdata_in[2:0];
      mode_q    <= mode_t'(reg_wdata_in[5:3]);
      ext_q     <= reg_wdata_in[`CTRL0_EXT];
    end
  end

  // Control registers 1 and 2.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sweep_sel_q <= 2'h0;
      res10_q     <= 1'b0;
      div_sel_q   <= 2'h0;
      vref_q      <= 1'b0;
      sh_q        <= 1'b0;
      psel_q      <= 1'b0;
    end else begin
      if (wr_c1) begin
        sweep_sel_q <= reg_wdata_in[1:0];
        res10_q     <= reg_wdata_in[`CTRL1_RES10];
        div_sel_q   <= reg_wdata_in[4:3];
        vref_q      <= reg_wdata_in[`CTRL1_VREF];
      end
      if (wr_c2) begin
        sh_q   <= reg_wdata_in[`CTRL2_SH];
        psel_q <= reg_wdata_in[`CTRL2_PCLK];
      end
    end
  end

  // The ladder follows the connect bit; cleared means no ladder current.
  assign vref_connect_out = vref_q;

  // ****************************************************************
  // Trigger detection.
  // ****************************************************************
  // Two-stage synchroniser plus one stage for edge detection.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trg_s1_q <= 1'b1;
      trg_s2_q <= 1'b1;
      trg_s3_q <= 1'b1;
    end else begin
      trg_s1_q <= external_trigger_input_in;
      trg_s2_q <= trg_s1_q;
      trg_s3_q <= trg_s2_q;
    end
  end

  // Start, restart and abort conditions.
  assign abort     = wr_c0 && !reg_wdata_in[`CTRL0_START];
  assign sw_start  = wr_c0 && reg_wdata_in[`CTRL0_START] && !start_q
                     && !reg_wdata_in[`CTRL0_EXT];
  assign ext_start = start_q && ext_q && trg_s3_q && !trg_s2_q && !wr_c0;
  assign begin_conv = sw_start || ext_start;

  // Start flag: a software write wins over the hardware clear.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      start_q <= 1'b0;
    end else if (wr_c0) begin
      start_q <= reg_wdata_in[`CTRL0_START];
    end else if (done && stop_at_end && !ext_q) begin
      start_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Conversion clock and length.
  // ****************************************************************
  // Divider period in main clock cycles, from prescale and divide select.
  always_comb begin
    case (div_sel_q)
      2'h0:    period = 4'h1;
      2'h1:    period = 4'h2;
      default: period = 4'h4;
    endcase
    if (!psel_q) begin
      period = {period[2:0], 1'b0};
    end
    period_m1 = period[2:0] - 3'h1;
  end

  // Cycles per pin from sample-hold and resolution.
  always_comb begin
    case ({sh_q, res10_q})
      2'h0:    len = `CYC_8B_PLAIN;
      2'h1:    len = `CYC_10B_PLAIN;
      2'h2:    len = `CYC_8B_SH;
      default: len = `CYC_10B_SH;
    endcase
  end

  assign tick = (state_q == ST_CONV) && (div_q == period_m1);
  assign done = tick && (cnt_q == len - 6'h01);

  // Main clock divider producing the conversion clock tick.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_q <= 3'h0;
    end else if (begin_conv || (state_q != ST_CONV) || tick) begin
      div_q <= 3'h0;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end

  // Conversion clock counter within one pin.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= 6'h00;
    end else if (begin_conv || done) begin
      cnt_q <= 6'h00;
    end else if (tick) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // ****************************************************************
  // Sequencer.
  // ****************************************************************
  assign mode_now  = wr_c0 ? mode_t'(reg_wdata_in[5:3]) : mode_q;
  assign first_pin = ((mode_now == MODE_ONESHOT) || (mode_now == MODE_REPEAT))
                     ? (wr_c0 ? reg_wdata_in[2:0] : pin_sel_q) : 3'h0;
  assign last_pin  = {sweep_sel_q, 1'b1};

  // What happens after each pin, per mode.
  always_comb begin
    stop_at_end = 1'b1;
    irq_at_end  = 1'b1;
    next_pin    = pin_q;
    case (mode_q)
      MODE_ONESHOT: begin
        stop_at_end = 1'b1;
        irq_at_end  = 1'b1;
      end
      MODE_REPEAT: begin
        stop_at_end = 1'b0;
        irq_at_end  = 1'b0;
      end
      MODE_SWEEP1X: begin
        stop_at_end = (pin_q == last_pin);
        irq_at_end  = (pin_q == last_pin);
        next_pin    = pin_q + 3'h1;
      end
      MODE_RSWEEP0: begin
        stop_at_end = 1'b0;
        irq_at_end  = 1'b0;
        next_pin    = (pin_q == last_pin) ? 3'h0 : pin_q + 3'h1;
      end
      MODE_RSWEEP1: begin
        stop_at_end = 1'b0;
        irq_at_end  = 1'b0;
        next_pin    = (pin_q != 3'h0) ? 3'h0 : alt_q;
      end
      default: begin
        stop_at_end = 1'b1;
        irq_at_end  = 1'b1;
      end
    endcase
  end

  // Converter state.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (begin_conv) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (abort) begin
            state_q <= ST_IDLE;
          end else if (!begin_conv && done && stop_at_end) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Pin under conversion and the rotating partner for repeat sweep 1.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_q <= 3'h0;
      alt_q <= `RST_ALT_PIN;
    end else if (begin_conv) begin
      pin_q <= first_pin;
      alt_q <= `RST_ALT_PIN;
    end else if (done) begin
      pin_q <= next_pin;
      if ((mode_q == MODE_RSWEEP1) && (pin_q == 3'h0)) begin
        alt_q <= (alt_q == 3'h7) ? 3'h1 : alt_q + 3'h1;
      end
    end
  end

  // ****************************************************************
  // Result registers and interrupt.
  // ****************************************************************
  // Each pin's register captures at the end of its own conversion.
  for (genvar i = 0; i < 8; i++) begin : g_res
    always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        res_lo_q[i] <= 8'h00;
        res_hi_q[i] <= 2'h0;
      end else if (done && (pin_q == 3'(i))) begin
        if (res10_q) begin
          res_lo_q[i] <= conv_result_in[7:0];
          res_hi_q[i] <= conv_result_in[9:8];
        end else begin
          res_lo_q[i] <= conv_result_in[9:2];
        end
      end
    end
  end

  // Request rises on the same edge that stores the result.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= done && irq_at_end && !abort;
    end
  end

  // ****************************************************************
  // Register read.
  // ****************************************************************
  always_comb begin
    case (reg_addr_in)
      `OFS_CTRL0:  rd_mux = {ext_q, start_q, mode_q, pin_sel_q};
      `OFS_CTRL1:  rd_mux = {2'h0, vref_q, div_sel_q, res10_q, sweep_sel_q};
      `OFS_CTRL2:  rd_mux = {6'h00, psel_q, sh_q};
      `OFS_STATUS: rd_mux = {4'h0, pin_q, (state_q == ST_CONV)};
      default: begin
        if (reg_addr_in[7:4] == `OFS_RES_BASE) begin
          rd_mux = reg_addr_in[0] ? {6'h00, res_hi_q[reg_addr_in[3:1]]}
                                  : res_lo_q[reg_addr_in[3:1]];
        end else begin
          rd_mux = 8'h00;
        end
      end
    endcase
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_rd_in ? rd_mux : 8'h00;
    end
  end

  // Output assignments.
  assign reg_rdata_out      = rdata_q;
  assign analog_pin_sel_out = pin_q;
  assign sample_hold_out    = sh_q;
  assign conv_active_out    = (state_q == ST_CONV);
  assign adc_clock_tick_out = tick;
  assign adc_irq_out        = irq_q;
  assign conv_state_out     = state_q;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  logic [9:0] cyc_q;
  logic [8:0] exp_cyc;
  logic [7:0] conv_lo;
  logic [7:0] conv_up;
  logic       wd_vref;
  assign exp_cyc = 9'(len) * 9'(period);
  assign conv_lo = conv_result_in[7:0];
  assign conv_up = conv_result_in[9:2];
  assign wd_vref = reg_wdata_in[`CTRL1_VREF];

  // Counts cycles spent converting the current pin.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cyc_q <= 10'h000;
    end else if (begin_conv || done) begin
      cyc_q <= 10'h001;
    end else if (state_q == ST_CONV) begin
      cyc_q <= cyc_q + 10'h001;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_oneshot_end;
    (state_q == ST_CONV) ##0 (done && (mode_q == MODE_ONESHOT) && !wr_c0 && !ext_start);
  endsequence

  sequence s_irq_pulse;
    adc_irq_out ##1 !adc_irq_out;
  endsequence

  a_vref_ladder: assert property (wr_c1 |=> (vref_connect_out == $past(wd_vref)))
    else $error("ladder connect does not follow its bit");
  a_soft_start: assert property (sw_start |=> (conv_active_out && (cnt_q == 6'h00)))
    else $error("software start did not begin conversion");
  a_ext_start: assert property (ext_start |=> (conv_active_out && (div_q == 3'h0)))
    else $error("trigger edge did not restart conversion");
  a_conv_len: assert property (done |-> (cyc_q == 10'(exp_cyc)))
    else $error("pin conversion length wrong");
  a_flag_clear: assert property ((s_oneshot_end ##0 !ext_q) |=> (!start_q && !conv_active_out))
    else $error("one-shot end did not stop and clear flag");
  a_flag_keep: assert property ((s_oneshot_end ##0 ext_q) |=> start_q)
    else $error("start flag lost under external trigger");
  a_abort_conv: assert property ((abort && conv_active_out) |=> (!conv_active_out && !adc_irq_out))
    else $error("abort did not stop conversion");
  a_irq_oneshot: assert property (s_oneshot_end |=> s_irq_pulse)
    else $error("one-shot end gave no single interrupt pulse");
  a_irq_order: assert property (adc_irq_out |-> $past(done))
    else $error("interrupt before result store");
  a_store_ten: assert property ((s_oneshot_end ##0 res10_q) |=> (res_lo_q[pin_q] == $past(conv_lo)) && (res_hi_q[pin_q] == $past(conv_result_in[9:8])))
    else $error("ten-bit result misplaced");
  a_store_eight: assert property ((s_oneshot_end ##0 !res10_q) |=> (res_lo_q[pin_q] == $past(conv_up)))
    else $error("eight-bit result misplaced");

endmodule : sar_adc_conversion_control

// File: tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import adc_pkg::*;

  // ******************************************************************
  // Design ports and run counters.
  // ******************************************************************
  logic       mclk_in                   = 1'b0;
  logic       rst_n_in                  = 1'b0;
  logic [7:0] reg_addr_in               = 8'h00;
  logic [7:0] reg_wdata_in              = 8'h00;
  logic       reg_wr_in                 = 1'b0;
  logic       reg_rd_in                 = 1'b0;
  logic       external_trigger_input_in = 1'b1;
  logic [9:0] conv_result_in            = 10'h000;
  logic [7:0] reg_rdata_out;
  logic       vref_connect_out;
  logic [2:0] analog_pin_sel_out;
  logic       sample_hold_out;
  logic       conv_active_out;
  logic       adc_clock_tick_out;
  logic       adc_irq_out;
  state_t     conv_state_out;
  int         error_cnt                 = 0;
  int         tests_run                 = 0;

  // The 100 ns clock.
  always #50 mclk_in = ~mclk_in;

  sar_adc_conversion_control dut (
    .mclk_in                   (mclk_in),
    .rst_n_in                  (rst_n_in),
    .reg_addr_in               (reg_addr_in),
    .reg_wdata_in              (reg_wdata_in),
    .reg_wr_in                 (reg_wr_in),
    .reg_rd_in                 (reg_rd_in),
    .reg_rdata_out             (reg_rdata_out),
    .external_trigger_input_in (external_trigger_input_in),
    .conv_result_in            (conv_result_in),
    .vref_connect_out          (vref_connect_out),
    .analog_pin_sel_out        (analog_pin_sel_out),
    .sample_hold_out           (sample_hold_out),
    .conv_active_out           (conv_active_out),
    .adc_clock_tick_out        (adc_clock_tick_out),
    .adc_irq_out               (adc_irq_out),
    .conv_state_out            (conv_state_out)
  );

  // ******************************************************************
  // Shared helpers.
  // ******************************************************************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One-cycle write strobe launched just after a rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge mclk_in);
    reg_wr_in    <= 1'b0;
  endtask : wr

  // Read data is taken in the cycle after the strobe, at its middle.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge mclk_in);
    reg_rd_in   <= 1'b0;
    @(negedge mclk_in);
    d = reg_rdata_out;
  endtask : rd

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict

  // ******************************************************************
  // Scenarios.
  // ******************************************************************
  // Reset values, unmapped and read-only places, ladder connection.
  task automatic test_reset;
    logic [7:0] v;
    chk("state after reset", 16'h0001, conv_state_out);
    chk("ladder after reset", 16'h0000, vref_connect_out);
    rd(8'h00, v); chk("ctrl0 reset", 16'h0000, v);
    rd(8'h01, v); chk("ctrl1 reset", 16'h0000, v);
    rd(8'hFF, v); chk("unmapped read", 16'h0000, v);
    wr(8'h03, 8'hFF);
    rd(8'h03, v); chk("status read only", 16'h0000, v);
    wr(8'h01, 8'h20);
    @(negedge mclk_in);
    chk("ladder connected", 16'h0001, vref_connect_out);
    wr(8'h01, 8'h00);
    @(negedge mclk_in);
    chk("ladder isolated", 16'h0000, vref_connect_out);
  endtask : test_reset

  // One software-started conversion, timed and its result placed.
  task automatic one_shot(input logic [2:0] pin, input logic res10, input logic sh,
                          input logic pclk, input logic [1:0] dv, input logic [9:0] res,
                          input logic [15:0] ncyc);
    logic [7:0]  lo;
    logic [7:0]  hi;
    logic [15:0] cnt;
    logic [15:0] tk;
    rd(8'h11 + {4'h0, pin, 1'b0}, hi);
    wr(8'h01, {2'b00, 1'b1, dv, res10, 2'b00});
    wr(8'h02, {6'h00, pclk, sh});
    conv_result_in <= res;
    wr(8'h00, {2'b01, 3'h0, pin});
    cnt = 16'h0000;
    tk  = 16'h0000;
    @(negedge mclk_in);
    chk("start on flag", 16'h0001, conv_active_out);
    chk("pin select", pin, analog_pin_sel_out);
    chk("sample hold", sh, sample_hold_out);
    while (conv_active_out === 1'b1 && cnt < 16'h0BB8) begin
      cnt++;
      if (adc_clock_tick_out === 1'b1) tk++;
      @(negedge mclk_in);
    end
    chk("conversion cycles", ncyc, cnt);
    chk("conversion clocks", res10 ? (sh ? 16'h0021 : 16'h003B) : (sh ? 16'h001C : 16'h0031), tk);
    chk("irq at end", 16'h0001, adc_irq_out);
    @(negedge mclk_in);
    chk("irq width", 16'h0000, adc_irq_out);
    rd(8'h00, lo); chk("start flag cleared", 16'h0000, lo & 8'h40);
    rd(8'h10 + {4'h0, pin, 1'b0}, lo);
    chk("even byte", res10 ? res[7:0] : res[9:2], lo);
    rd(8'h11 + {4'h0, pin, 1'b0}, lo);
    chk("odd byte", res10 ? {6'h00, res[9:8]} : hi, lo);
  endtask : one_shot

  // A zero written to the flag mid-conversion stops it with no store.
  task automatic abort_conv;
    logic [7:0] b;
    logic [7:0] lo;
    logic       seen;
    rd(8'h1E, b);
    wr(8'h01, 8'h34);
    wr(8'h02, 8'h01);
    conv_result_in <= 10'h155;
    wr(8'h00, 8'h47);
    repeat (20) @(posedge mclk_in);
    wr(8'h00, 8'h07);
    @(negedge mclk_in);
    chk("active after abort", 16'h0000, conv_active_out);
    seen = 1'b0;
    repeat (300) begin
      @(negedge mclk_in);
      seen |= adc_irq_out;
    end
    chk("irq after abort", 16'h0000, seen);
    rd(8'h1E, lo); chk("result kept", b, lo);
  endtask : abort_conv

  // Falling edges on the trigger pin start and restart a conversion.
  task automatic ext_trig;
    logic [15:0] cnt;
    logic [7:0]  lo;
    wr(8'h01, 8'h20);
    wr(8'h02, 8'h02);
    wr(8'h00, 8'hC2);
    repeat (10) @(negedge mclk_in);
    chk("no start without edge", 16'h0000, conv_active_out);
    @(posedge mclk_in);
    external_trigger_input_in <= 1'b0;
    cnt = 16'h0000;
    while (conv_active_out !== 1'b1 && cnt < 16'h0008) begin
      cnt++;
      @(negedge mclk_in);
    end
    chk("edge starts", 16'h0001, conv_active_out);
    repeat (20) @(posedge mclk_in);
    external_trigger_input_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    external_trigger_input_in <= 1'b0;
    cnt = 16'h0000;
    @(negedge mclk_in);
    while (conv_active_out === 1'b1 && cnt < 16'h00C8) begin
      cnt++;
      @(negedge mclk_in);
    end
    chk("retrigger restarts", 16'h0001, cnt >= 16'h0031 && cnt <= 16'h003A);
    chk("irq on ext end", 16'h0001, adc_irq_out);
    rd(8'h00, lo); chk("ext flag stays", 16'h0040, lo & 8'h40);
    wr(8'h00, 8'h00);
    @(posedge mclk_in);
    external_trigger_input_in <= 1'b1;
  endtask : ext_trig

  // The four other modes: repeat modes run on, single sweep stops.
  task automatic modes;
    logic [15:0] cnt;
    logic        seen;
    for (int m = 1; m < 5; m++) begin
      wr(8'h00, {2'b01, m[2:0], 3'h0});
      seen = 1'b0;
      cnt  = 16'h0000;
      repeat (300) begin
        @(negedge mclk_in);
        seen |= adc_irq_out;
        if (conv_active_out === 1'b1) cnt++;
      end
      if (m == 2) begin
        chk("sweep irq", 16'h0001, seen);
        chk("sweep length", 16'h0001, cnt >= 16'h0062 && cnt <= 16'h006E);
      end else begin
        chk("repeat no irq", 16'h0000, seen);
        chk("repeat runs on", 16'h0001, conv_active_out);
      end
      wr(8'h00, 8'h00);
      @(negedge mclk_in);
      chk("stopped", 16'h0000, conv_active_out);
    end
  endtask : modes

  // ******************************************************************
  // Main sequence and watchdog.
  // ******************************************************************
  initial begin
    repeat (8) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    @(negedge mclk_in);
    test_reset;
    one_shot(3'h0, 1'b0, 1'b0, 1'b1, 2'h0, 10'h2A5, 16'h0031);
    one_shot(3'h3, 1'b1, 1'b0, 1'b1, 2'h1, 10'h35A, 16'h0076);
    one_shot(3'h5, 1'b0, 1'b1, 1'b0, 2'h0, 10'h1C3, 16'h0038);
    one_shot(3'h7, 1'b1, 1'b1, 1'b0, 2'h2, 10'h2F0, 16'h0108);
    abort_conv;
    ext_trig;
    modes;
    print_verdict;
  end

  // Cuts a hang short well after the expected few thousand cycles.
  initial begin
    #(100 * 20000);
    chk("run finished in time", 16'h0001, 16'h0000);
    print_verdict;
  end

endmodule : tb_top
